// File: tsio_pkg.sv
// Shared constants, types and helpers of the timed serializing I/O port
package tsio_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DATA = 8'h04;
  localparam logic [7:0] OFF_COND = 8'h08;
  localparam logic [7:0] OFF_TIME = 8'h0C;
  localparam logic [7:0] OFF_COUNT = 8'h10;
  localparam logic [7:0] OFF_STAMP = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_ARM = 8'h1C;
  localparam logic [7:0] OFF_CLKB1 = 8'h20;
  localparam logic [7:0] OFF_CLKB5 = 8'h30;
  // ****************************************
  // Control fields and reset values
  // ****************************************
  localparam int CTL_EN = 0;
  localparam int CTL_DIR = 1;
  localparam int CTL_CEN = 2;
  localparam int CTL_CNEQ = 3;
  localparam int CTL_TIMED = 4;
  localparam int CTL_SOUT = 5;
  localparam int CTL_SIN = 6;
  localparam int CTL_CB_LO = 8;
  localparam int CLKB_EXT = 8;
  localparam int NUM_CLKB = 6;
  localparam int CNT_W = 16;
  localparam int REF_CLK_MHZ = 100;
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [2:0] CB_SEL_RST = 3'h0;
  localparam logic [7:0] CB_DIV_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_WAIT = 2'b01, ST_SHIFT = 2'b11, ST_DONE = 2'b10
  } tsio_state_e;
  typedef struct packed {
    logic op_in;
    logic [6:0] ctl;
    logic [2:0] cb_sel;
    logic [7:0] cb_div;
    logic cb_ext;
    logic [15:0] time_val;
    logic [31:0] cond_val;
    logic [31:0] data;
  } tsio_cfg_s;
  typedef struct packed {
    logic [31:0] data;
    logic [15:0] stamp;
  } tsio_res_s;
  function automatic logic [15:0] tsio_to_gray(input logic [15:0] b);
    return b ^ (b >> 1);
  endfunction : tsio_to_gray
  function automatic logic [15:0] tsio_from_gray(input logic [15:0] g);
    logic [15:0] b;
    b = g;
    for (int i = 14; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : tsio_from_gray
endpackage : tsio_pkg

// File: tsio_port.sv
// One timed serializing I/O port with register port and pin-side clock domain
`timescale 1ns/1ps
module tsio_port import tsio_pkg::*; #(
  parameter int PORT_W = 32
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic port_clk_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic [PORT_W-1:0] pin_in,
  output logic [PORT_W-1:0] pin_out,
  output logic [PORT_W-1:0] pin_oe_n_out,
  input wire logic incoming_strobe_in,
  output logic outgoing_strobe_out,
  input wire logic ext_clk_pin_in,
  input wire logic link_en_in,
  input wire logic [PORT_W-1:0] narrow_mask_in,
  output logic event_out
);
  localparam int SHIFTS = 32 / PORT_W;

  // ****************************************
  // Core-side registers
  // ****************************************
  logic [6:0] ctrl_r;
  logic [2:0] cb_sel_r;
  logic [31:0] cond_r;
  logic [15:0] time_r;
  logic [7:0] cb_div_r [1:NUM_CLKB-1];
  logic cb_ext_r [1:NUM_CLKB-1];
  logic [31:0] in_data_r;
  logic [15:0] stamp_r;
  logic in_valid_r;
  logic busy_r;
  logic req_tgl_r;
  logic ack_s1, ack_s2, ack_seen_r, ack_tgl_r;
  logic [15:0] cnt_g1, cnt_g2, cnt_gray_r;
  logic [15:0] count_bin;
  tsio_cfg_s xfer_r;
  tsio_res_s res_r;
  logic launch, done;
  logic op_in_nxt;
  logic [2:0] blk;

  // Launch on DATA (output) or ARM (input) write when enabled and idle
  assign launch = wr_in && !busy_r && ctrl_r[CTL_EN] &&
                  (addr_in == OFF_DATA || addr_in == OFF_ARM);
  assign op_in_nxt = (addr_in == OFF_ARM);
  assign done = ack_s2 ^ ack_seen_r;
  assign blk = cb_sel_r;
  assign count_bin = tsio_from_gray(cnt_g2);

  // Control and configuration writes
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_r <= CTRL_RST;
      cb_sel_r <= CB_SEL_RST;
      cond_r <= WORD_RST;
      time_r <= CNT_RST;
    end else if (wr_in) begin
      if (addr_in == OFF_CTRL) begin
        ctrl_r <= wdata_in[6:0];
        cb_sel_r <= wdata_in[CTL_CB_LO+2:CTL_CB_LO];
      end else if (addr_in == OFF_COND) begin
        cond_r <= wdata_in;
      end else if (addr_in == OFF_TIME) begin
        time_r <= wdata_in[15:0];
      end
    end
  end

  // Programmable clock blocks 1..5
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 1; i < NUM_CLKB; i++) begin
        cb_div_r[i] <= CB_DIV_RST;
        cb_ext_r[i] <= 1'b0;
      end
    end else if (wr_in && addr_in >= OFF_CLKB1 && addr_in <= OFF_CLKB5) begin
      cb_div_r[3'(((addr_in - OFF_CLKB1) >> 2) + 8'd1)] <= wdata_in[7:0];
      cb_ext_r[3'(((addr_in - OFF_CLKB1) >> 2) + 8'd1)] <= wdata_in[CLKB_EXT];
    end
  end

  // Snapshot held stable while the request crosses
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      xfer_r <= '0;
      req_tgl_r <= 1'b0;
    end else if (launch) begin
      xfer_r.op_in <= op_in_nxt;
      xfer_r.ctl <= ctrl_r;
      xfer_r.cb_sel <= cb_sel_r;
      xfer_r.cb_div <= (blk == 3'h0 || blk >= 3'(NUM_CLKB)) ? CB_DIV_RST : cb_div_r[blk];
      xfer_r.cb_ext <= (blk == 3'h0 || blk >= 3'(NUM_CLKB)) ? 1'b0 : cb_ext_r[blk];
      xfer_r.time_val <= time_r;
      xfer_r.cond_val <= cond_r;
      xfer_r.data <= wdata_in;
      req_tgl_r <= !req_tgl_r;
    end
  end

  // Busy, answer capture and scheduler event
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      busy_r <= 1'b0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_seen_r <= 1'b0;
      in_data_r <= WORD_RST;
      stamp_r <= CNT_RST;
      event_out <= 1'b0;
    end else begin
      ack_s1 <= ack_tgl_r;
      ack_s2 <= ack_s1;
      ack_seen_r <= ack_s2;
      event_out <= done;
      if (launch) begin
        busy_r <= 1'b1;
      end else if (done) begin
        busy_r <= 1'b0;
      end
      if (done) begin
        stamp_r <= res_r.stamp;
        if (xfer_r.op_in) begin
          in_data_r <= res_r.data;
        end
      end
    end
  end

  // Input-valid flag: new data wins over a read
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      in_valid_r <= 1'b0;
    end else if (done && xfer_r.op_in) begin
      in_valid_r <= 1'b1;
    end else if (rd_in && addr_in == OFF_DATA) begin
      in_valid_r <= 1'b0;
    end
  end

  // Gray counter crossing and read data one cycle later
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_g1 <= CNT_RST;
      cnt_g2 <= CNT_RST;
      rdata_out <= WORD_RST;
    end else begin
      cnt_g1 <= cnt_gray_r;
      cnt_g2 <= cnt_g1;
      if (!rd_in) begin
        rdata_out <= WORD_RST;
      end else if (addr_in == OFF_CTRL) begin
        rdata_out <= {21'h0, cb_sel_r, 1'b0, ctrl_r};
      end else if (addr_in == OFF_DATA) begin
        rdata_out <= in_data_r;
      end else if (addr_in == OFF_COND) begin
        rdata_out <= cond_r;
      end else if (addr_in == OFF_TIME) begin
        rdata_out <= {16'h0000, time_r};
      end else if (addr_in == OFF_COUNT) begin
        rdata_out <= {16'h0000, count_bin};
      end else if (addr_in == OFF_STAMP) begin
        rdata_out <= {16'h0000, stamp_r};
      end else if (addr_in == OFF_STATUS) begin
        rdata_out <= {30'h0000_0000, in_valid_r, busy_r};
      end else if (addr_in >= OFF_CLKB1 && addr_in <= OFF_CLKB5) begin
        rdata_out <= {23'h0, cb_ext_r[3'(((addr_in - OFF_CLKB1) >> 2) + 8'd1)],
                      cb_div_r[3'(((addr_in - OFF_CLKB1) >> 2) + 8'd1)]};
      end else begin
        rdata_out <= WORD_RST;
      end
    end
  end

  // ****************************************
  // Pin-side domain
  // ****************************************
  logic lrst_n1, lrst_n;
  logic [PORT_W-1:0] pin_s1, pin_s2, nm_s1, nm_s2;
  logic stb_s1, stb_s2, ext_s1, ext_s2, ext_s3, lnk_s1, lnk_s2;
  logic req_s1, req_s2, req_s3;
  tsio_cfg_s cfg_r;
  tsio_state_e st_r;
  logic [7:0] div_r;
  logic [15:0] cnt_r, tstamp_r;
  logic [31:0] sh_r;
  logic [5:0] beats_r;
  logic tick, go, beat, cond_ok, new_req;
  logic [PORT_W-1:0] cval;

  // Reset release synchronised to the port clock
  always_ff @(posedge port_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lrst_n1 <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lrst_n1 <= 1'b1;
      lrst_n <= lrst_n1;
    end
  end

  // Two-stage synchronisers for pins and the request toggle
  always_ff @(posedge port_clk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      nm_s1 <= '0;
      nm_s2 <= '0;
      {stb_s1, stb_s2, ext_s1, ext_s2, ext_s3} <= 5'h00;
      {lnk_s1, lnk_s2, req_s1, req_s2, req_s3} <= 5'h00;
    end else begin
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
      nm_s1 <= narrow_mask_in;
      nm_s2 <= nm_s1;
      {stb_s1, stb_s2} <= {incoming_strobe_in, stb_s1};
      {ext_s1, ext_s2, ext_s3} <= {ext_clk_pin_in, ext_s1, ext_s2};
      {lnk_s1, lnk_s2} <= {link_en_in, lnk_s1};
      {req_s1, req_s2, req_s3} <= {req_tgl_r, req_s1, req_s2};
    end
  end

  assign new_req = req_s2 ^ req_s3;
  assign cval = cfg_r.cond_val[PORT_W-1:0];
  // Pin condition, equal or not-equal
  assign cond_ok = cfg_r.ctl[CTL_CNEQ] ? (pin_s2 != cval) : (pin_s2 == cval);
  // Port clock from the selected clock block
  assign tick = (cfg_r.cb_sel == 3'h0) ? 1'b1 :
                cfg_r.cb_ext ? (ext_s2 && !ext_s3) :
                (div_r == cfg_r.cb_div);
  // Start when time, condition and strobe all agree
  assign go = st_r == ST_WAIT && tick && !lnk_s2 &&
              (!cfg_r.ctl[CTL_TIMED] || cnt_r == cfg_r.time_val) &&
              (!cfg_r.op_in || !cfg_r.ctl[CTL_CEN] || cond_ok) &&
              (!cfg_r.op_in || !cfg_r.ctl[CTL_SIN] || stb_s2);
  assign beat = go || (st_r == ST_SHIFT && tick && !lnk_s2 &&
                (!cfg_r.op_in || !cfg_r.ctl[CTL_SIN] || stb_s2));

  // Clock divider and free-running port counter
  always_ff @(posedge port_clk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      div_r <= CB_DIV_RST;
      cnt_r <= CNT_RST;
      cnt_gray_r <= CNT_RST;
    end else begin
      div_r <= tick ? CB_DIV_RST : div_r + 8'd1;
      if (tick) begin
        cnt_r <= cnt_r + 16'd1;
      end
      cnt_gray_r <= tsio_to_gray(cnt_r);
    end
  end

  // Transfer sequencer with shift serializer
  always_ff @(posedge port_clk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      st_r <= ST_IDLE;
      cfg_r <= '0;
      sh_r <= WORD_RST;
      beats_r <= 6'd0;
      tstamp_r <= CNT_RST;
      res_r <= '0;
      ack_tgl_r <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (new_req) begin
            cfg_r <= xfer_r;
            sh_r <= xfer_r.data;
            beats_r <= 6'd0;
            st_r <= ST_WAIT;
          end
        end
        ST_WAIT, ST_SHIFT: begin
          if (go) begin
            tstamp_r <= cnt_r;
          end
          if (beat) begin
            sh_r <= cfg_r.op_in ? 32'({pin_s2, sh_r} >> PORT_W) :
                    32'(sh_r >> PORT_W);
            beats_r <= beats_r + 6'd1;
            st_r <= (beats_r == 6'(SHIFTS - 1)) ? ST_DONE : ST_SHIFT;
          end
        end
        ST_DONE: begin
          res_r.data <= sh_r;
          res_r.stamp <= tstamp_r;
          ack_tgl_r <= !ack_tgl_r;
          st_r <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Pin drive, direction and outgoing strobe
  always_ff @(posedge port_clk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      pin_out <= '0;
      pin_oe_n_out <= '1;
      outgoing_strobe_out <= 1'b0;
    end else begin
      if (beat && !cfg_r.op_in) begin
        pin_out <= sh_r[PORT_W-1:0];
      end
      // One direction for the port, narrower ports and link take pins
      pin_oe_n_out <= ~({PORT_W{cfg_r.ctl[CTL_EN] && cfg_r.ctl[CTL_DIR] && !lnk_s2}}
                      & ~nm_s2);
      outgoing_strobe_out <= beat && !cfg_r.op_in && cfg_r.ctl[CTL_SOUT];
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_wait_then_shift;
    st_r == ST_WAIT ##1 st_r == ST_SHIFT || st_r == ST_DONE;
  endsequence
  sequence s_ack_seen;
    $changed(ack_s2) ##1 1'b1;
  endsequence

  a_width_legal: assert property (@(posedge clk_in) disable iff (!nrst_in)
    PORT_W == 1 || PORT_W == 4 || PORT_W == 8 || PORT_W == 16 || PORT_W == 32)
    else $error("illegal port width");
  a_dir_uniform: assert property (@(posedge port_clk_in) disable iff (!lrst_n)
    ((pin_oe_n_out | $past(nm_s2)) == '1) || ((~pin_oe_n_out | $past(nm_s2)) == '1)
    || $past(lnk_s2))
    else $error("mixed pin directions");
  a_link_release: assert property (@(posedge port_clk_in) disable iff (!lrst_n)
    lnk_s2 |=> pin_oe_n_out == '1)
    else $error("pins driven while link enabled");
  a_narrow_wins: assert property (@(posedge port_clk_in) disable iff (!lrst_n)
    ##1 ($past(nm_s2) & ~pin_oe_n_out) == '0)
    else $error("shared pin driven by wider port");
  a_count_wrap: assert property (@(posedge port_clk_in) disable iff (!lrst_n)
    tick |=> cnt_r == 16'($past(cnt_r) + 16'd1))
    else $error("counter step wrong");
  a_timed_start: assert property (@(posedge port_clk_in) disable iff (!lrst_n)
    st_r == ST_DONE && cfg_r.ctl[CTL_TIMED] |-> tstamp_r == cfg_r.time_val)
    else $error("timed transfer off schedule");
  a_stamp_latch: assert property (@(posedge port_clk_in) disable iff (!lrst_n)
    s_wait_then_shift |-> tstamp_r == $past(cnt_r))
    else $error("timestamp not latched");
  a_busy_accept: assert property (@(posedge clk_in) disable iff (!nrst_in)
    launch |=> busy_r && req_tgl_r != $past(req_tgl_r))
    else $error("access not taken in one cycle");
  a_event_raise: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_ack_seen |-> event_out && !busy_r)
    else $error("no event after transfer");
  a_strobe_out: assert property (@(posedge port_clk_in) disable iff (!lrst_n)
    outgoing_strobe_out |-> !cfg_r.op_in && $past(beat))
    else $error("strobe without data");
  a_full_width: assert property (@(posedge port_clk_in) disable iff (!lrst_n)
    st_r == ST_DONE |-> beats_r == 6'(SHIFTS))
    else $error("partial width transfer");
endmodule : tsio_port

// File: tsio_ext_model.sv
// Pin-side hardware model facing one timed serializing port
`timescale 1ns/1ps
module tsio_ext_model #(
  parameter int W = 8
) (
  input wire logic pclk_in,
  input wire logic [W-1:0] pin_out_in,
  input wire logic [W-1:0] oe_n_in,
  input wire logic strobe_in,
  input wire logic [W-1:0] drive_in,
  input wire logic hold_in,
  output logic [W-1:0] pin_level_out,
  output logic ready_out
);
  // ****************************************
  // Pin wire and capture
  // ****************************************
  logic [W-1:0] beat_d[$];
  logic [W-1:0] beat_oe[$];
  int beat_t[$];
  int tick_r = 0;
  // Wire level: device value where it drives, else our own drive
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pin_level_out[i] = oe_n_in[i] ? drive_in[i] : pin_out_in[i];
    end
  end
  // Ready unless the bench asks us to hold off the port
  assign ready_out = !hold_in;
  // Log each beat marked by the strobe, with port-clock time
  always @(posedge pclk_in) begin
    tick_r <= tick_r + 1;
    if (strobe_in === 1'b1) begin
      beat_d.push_back(pin_out_in);
      beat_oe.push_back(oe_n_in);
      beat_t.push_back(tick_r);
    end
  end
endmodule : tsio_ext_model

// File: timed_serializing_io_ports_tb.sv
// Self-checking bench for the timed serializing port
`timescale 1ns/1ps
module timed_serializing_io_ports_tb import tsio_pkg::*;;
  // ****************************************
  // Signals and instances
  // ****************************************
  localparam int W = 8;
  localparam logic [31:0] OUTC = (32'h1 << CTL_EN) | (32'h1 << CTL_DIR) | (32'h1 << CTL_SOUT);
  localparam logic [31:0] INC = 32'h0000_0001;
  logic clk_in = 1'b0;
  logic pclk = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [W-1:0] pin_lvl;
  logic [W-1:0] pin_o;
  logic [W-1:0] oe_n;
  logic [W-1:0] drv = 8'h00;
  logic [W-1:0] mask = 8'h00;
  logic strb;
  logic rdy;
  logic evt;
  logic ext_ck = 1'b0;
  logic link = 1'b0;
  logic ext_run = 1'b0;
  logic hold = 1'b0;
  int ediv = 0;
  int cyc = 0;
  int n_mismatch = 0;
  int comparisons = 0;
  tsio_port #(.PORT_W(W)) uut (
    .clk_in(clk_in), .nrst_in(nrst_in), .port_clk_in(pclk), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .pin_in(pin_lvl),
    .pin_out(pin_o), .pin_oe_n_out(oe_n), .incoming_strobe_in(rdy),
    .outgoing_strobe_out(strb), .ext_clk_pin_in(ext_ck), .link_en_in(link),
    .narrow_mask_in(mask), .event_out(evt));
  tsio_ext_model #(.W(W)) far (
    .pclk_in(pclk), .pin_out_in(pin_o), .oe_n_in(oe_n), .strobe_in(strb),
    .drive_in(drv), .hold_in(hold), .pin_level_out(pin_lvl), .ready_out(rdy));
  // Core clock and a port clock of unrelated phase
  always #4 clk_in = ~clk_in;
  initial begin
    #3;
    forever #24 pclk = ~pclk;
  end
  // External port clock, period of ten port clocks, only while asked
  always @(posedge pclk) begin
    if (ext_run) begin
      ediv <= (ediv == 4) ? 0 : ediv + 1;
      if (ediv == 4) ext_ck <= ~ext_ck;
    end
  end
  // Hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string n, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask : check
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : bus_rd
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    bus_rd(a, d);
    check(n, d, e);
  endtask : rd_chk
  task automatic wait_evt(input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge clk_in);
      #1;
      if (evt === 1'b1) break;
    end
    check("event", 32'(i < lim), 32'h0000_0001);
  endtask : wait_evt
  task automatic send(input logic [31:0] ctl, input logic [31:0] d);
    far.beat_d.delete();
    far.beat_oe.delete();
    far.beat_t.delete();
    bus_wr(OFF_CTRL, ctl);
    bus_wr(OFF_DATA, d);
  endtask : send
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic s_reset;
    logic [31:0] a;
    logic [31:0] b;
    rd_chk("ctrl", OFF_CTRL, 32'h0000_0000);
    rd_chk("clkb1", OFF_CLKB1, 32'h0000_0000);
    rd_chk("unmapped", 8'hFC, 32'h0000_0000);
    bus_wr(OFF_DATA, 32'h0000_00AA);
    rd_chk("off_busy", OFF_STATUS, 32'h0000_0000);
    check("oe_idle", {24'h0, oe_n}, 32'h0000_00FF);
    bus_rd(OFF_COUNT, a);
    repeat (20) @(posedge pclk);
    bus_rd(OFF_COUNT, b);
    check("count_run", 32'(16'(b - a) >= 19 && 16'(b - a) <= 22), 32'h0000_0001);
  endtask : s_reset
  task automatic s_out;
    mask <= 8'hF0;
    send(OUTC, 32'h1234_5678);
    wait_evt(400);
    check("beats", 32'(far.beat_d.size()), 32'h0000_0004);
    for (int i = 0; i < 4; i++) begin
      check("beat", {24'h0, far.beat_d[i]}, (32'h1234_5678 >> (8 * i)) & 32'hFF);
      check("oe_mask", {24'h0, far.beat_oe[i]}, 32'h0000_00F0);
    end
    rd_chk("idle", OFF_STATUS, 32'h0000_0000);
    mask <= 8'h00;
  endtask : s_out
  task automatic s_timed;
    logic [31:0] c;
    logic [31:0] s;
    bus_rd(OFF_COUNT, c);
    bus_wr(OFF_TIME, {16'h0, c[15:0] + 16'h003C});
    send(OUTC | (32'h1 << CTL_TIMED), 32'hCAFE_0001);
    repeat (40) @(posedge pclk);
    check("early", 32'(far.beat_d.size()), 32'h0000_0000);
    wait_evt(800);
    bus_rd(OFF_STAMP, s);
    check("stamp", s, {16'h0, c[15:0] + 16'h003C});
  endtask : s_timed
  task automatic s_in;
    drv <= 8'hA5;
    hold <= 1'b1;
    bus_wr(OFF_CTRL, INC | (32'h1 << CTL_SIN));
    bus_wr(OFF_ARM, 32'h0000_0000);
    repeat (20) @(posedge pclk);
    #1;
    check("oe_in", {24'h0, oe_n}, 32'h0000_00FF);
    rd_chk("held", OFF_STATUS, 32'h0000_0001);
    hold <= 1'b0;
    wait_evt(400);
    rd_chk("valid", OFF_STATUS, 32'h0000_0002);
    rd_chk("in_word", OFF_DATA, 32'hA5A5_A5A5);
    rd_chk("valid_clr", OFF_STATUS, 32'h0000_0000);
  endtask : s_in
  task automatic s_cond;
    logic [31:0] d;
    logic [7:0] pre [2] = '{8'h00, 8'h3C};
    logic [7:0] post [2] = '{8'h3C, 8'h55};
    for (int m = 0; m < 2; m++) begin
      drv <= pre[m];
      bus_wr(OFF_COND, 32'h0000_003C);
      bus_wr(OFF_CTRL, INC | (32'h1 << CTL_CEN) | (32'(m) << CTL_CNEQ));
      bus_wr(OFF_ARM, 32'h0000_0000);
      repeat (20) @(posedge pclk);
      rd_chk("waiting", OFF_STATUS, 32'h0000_0001);
      drv <= post[m];
      wait_evt(400);
      bus_rd(OFF_DATA, d);
      check("cond_val", {24'h0, d[7:0]}, {24'h0, post[m]});
    end
  endtask : s_cond
  task automatic s_link;
    link <= 1'b1;
    send(OUTC, 32'h0F0E_0D0C);
    bus_wr(OFF_DATA, 32'hFFFF_FFFF);
    repeat (20) @(posedge pclk);
    check("link_oe", {24'h0, oe_n}, 32'h0000_00FF);
    check("link_beats", 32'(far.beat_d.size()), 32'h0000_0000);
    rd_chk("link_busy", OFF_STATUS, 32'h0000_0001);
    link <= 1'b0;
    wait_evt(400);
    for (int i = 0; i < 4; i++) begin
      check("kept_word", {24'h0, far.beat_d[i]}, 32'(12 + i));
    end
  endtask : s_link
  task automatic s_clkb;
    logic [31:0] cfg [2] = '{32'h0000_0002, 32'h0000_0100};
    int gap [2] = '{3, 10};
    for (int k = 0; k < 2; k++) begin
      ext_run <= (k == 1);
      bus_wr(OFF_CLKB1, cfg[k]);
      send(OUTC | (32'h1 << CTL_CB_LO), 32'h8765_4321);
      wait_evt(1500);
      for (int i = 1; i < 4; i++) begin
        check("beat_gap", 32'(far.beat_t[i] - far.beat_t[i-1]), 32'(gap[k]));
      end
    end
    ext_run <= 1'b0;
  endtask : s_clkb
  task automatic print_verdict;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict
  // Main sequence, ending with a second reset
  initial begin
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge pclk);
    s_reset();
    s_out();
    s_timed();
    s_in();
    s_cond();
    s_link();
    s_clkb();
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (3) @(posedge pclk);
    @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge pclk);
    rd_chk("ctrl_rst", OFF_CTRL, 32'h0000_0000);
    print_verdict();
  end
endmodule : timed_serializing_io_ports_tb
